/* verif/tb_windowed_watchdog_timer.sv */
// self-checking bench for the windowed watchdog register slave
`timescale 1ns/10ps
module tb_windowed_watchdog_timer
   import wwd_pkg::*;
();
   logic mclk, rst_b, avs_read, avs_write, slow_clk, proc_debug, sys_idle;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic avs_waitrequest, fault_irq, fault_request, processor_only_reset;
   int num_errors = 0;
   int n_tests = 0;

   // short divider keeps the slow clock stimulus brief
   wwd_watchdog #(.DIV(2)) i_dut (.mclk(mclk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .slow_clk(slow_clk),
      .proc_debug(proc_debug), .sys_idle(sys_idle), .fault_irq(fault_irq),
      .fault_request(fault_request),
      .processor_only_reset(processor_only_reset));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic pin(input string nm, input logic got, input logic exp);
      chk(nm, {31'h0, got}, {31'h0, exp});
   endtask : pin

   // request held until waitrequest is seen low at an edge
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [31:0] exp,
      input string nm);
      logic [31:0] d;
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge mclk);
      chk(nm, d, exp);
   endtask : rd

   // slow edges six cycles apart so the synchroniser sees each one
   task automatic slow(input int n);
      repeat (n) begin
         slow_clk <= 1'b1;
         repeat (3) @(posedge mclk);
         slow_clk <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
   endtask : slow

   task automatic reset_dut();
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
   endtask : reset_dut

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      complete_run();
   end

   initial begin
      {rst_b, avs_read, avs_write, slow_clk, proc_debug, sys_idle} = 6'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      reset_dut();
      rd(WWD_CFG_OFS, WWD_CFG_RESET, "cfg reset");
      rd(WWD_STS_OFS, 32'h0, "status reset");
      rd(WWD_CMD_OFS, 32'h0, "cmd read");
      rd(5'h14, 32'h0, "unmapped read");
      rd(WWD_CNT_OFS, 32'h0000_0FFF, "count reset");
      $display("test reset values done");
      // window 8, reload 0x10, irq, reset, processor scope
      wr(WWD_CFG_OFS, 32'h0008_7010);
      wr(WWD_CFG_OFS, 32'h0000_0FFF);
      rd(WWD_CFG_OFS, 32'h0008_7010, "cfg once");
      rd(WWD_CNT_OFS, 32'h0000_0010, "count load");
      wr(WWD_CMD_OFS, 32'h5A00_0001);
      wr(WWD_CMD_OFS, 32'hA500_0000);
      // key lane switched off: the key byte reads as zero, so ignored
      avs_byteenable <= 4'h7;
      wr(WWD_CMD_OFS, 32'hA500_0001);
      avs_byteenable <= 4'hF;
      rd(WWD_STS_OFS, 32'h0, "ignored cmds");
      wr(WWD_CMD_OFS, 32'hA500_0001);
      rd(WWD_CNT_OFS, 32'h0000_0010, "count kept");
      pin("irq", fault_irq, 1'b1);
      pin("fault", fault_request, 1'b1);
      pin("scope", processor_only_reset, 1'b1);
      rd(WWD_STS_OFS, 32'h2, "window error");
      rd(WWD_STS_OFS, 32'h0, "status cleared");
      pin("irq cleared", fault_irq, 1'b0);
      pin("fault cleared", fault_request, 1'b0);
      wr(WWD_MASK_OFS, 32'h1);
      wr(WWD_CMD_OFS, 32'hA500_0001);
      rd(WWD_CNT_OFS, 32'h0000_0010, "count kept");
      pin("irq masked", fault_irq, 1'b0);
      rd(WWD_STS_OFS, 32'h2, "masked error");
      wr(WWD_MASK_OFS, 32'h3);
      slow(16);
      rd(WWD_CNT_OFS, 32'h0000_0008, "count ticks");
      slow(1);
      wr(WWD_CMD_OFS, 32'hA500_0001);
      slow(2);
      rd(WWD_CNT_OFS, 32'h0000_000F, "divider restart");
      rd(WWD_STS_OFS, 32'h0, "honoured restart");
      slow(32);
      rd(WWD_CNT_OFS, 32'h0000_0010, "underflow reload");
      pin("fault underflow", fault_request, 1'b1);
      rd(WWD_STS_OFS, 32'h1, "underflow flag");
      $display("test window and faults done");
      // both freezes, faults kept off the outputs
      reset_dut();
      wr(WWD_CFG_OFS, 32'h3FFF_0010);
      proc_debug <= 1'b1;
      slow(4);
      rd(WWD_CNT_OFS, 32'h0000_0010, "debug freeze");
      proc_debug <= 1'b0;
      sys_idle <= 1'b1;
      slow(4);
      rd(WWD_CNT_OFS, 32'h0000_0010, "idle freeze");
      sys_idle <= 1'b0;
      slow(34);
      rd(WWD_CNT_OFS, 32'h0000_0010, "quiet reload");
      pin("irq off", fault_irq, 1'b0);
      pin("fault off", fault_request, 1'b0);
      rd(WWD_STS_OFS, 32'h1, "quiet underflow");
      $display("test freeze done");
      // disabled timer still flags an early restart
      reset_dut();
      wr(WWD_CFG_OFS, 32'h0004_8010);
      slow(4);
      rd(WWD_CNT_OFS, 32'h0000_0010, "disabled");
      wr(WWD_CMD_OFS, 32'hA500_0001);
      rd(WWD_STS_OFS, 32'h2, "disabled error");
      $display("test disable done");
      complete_run();
   end
endmodule : tb_windowed_watchdog_timer

/* verif/wwd_watchdog_properties.sv */
// port-level assertion checker for the windowed watchdog
`timescale 1ns/10ps
module wwd_watchdog_props
   import wwd_pkg::*;
#(
   parameter int DIV = WWD_PRESCALE
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic slow_clk,
   input wire logic proc_debug,
   input wire logic sys_idle,
   input wire logic fault_irq,
   input wire logic fault_request,
   input wire logic processor_only_reset
);
   logic req_q;
   logic locked;
   logic [31:0] cfg_m;
   wire logic req = avs_read | avs_write;
   wire logic acc = req & ~avs_waitrequest;
   wire logic sts_rd = acc & avs_read & (avs_address == WWD_STS_OFS);

   // shadow of the write-once configuration, lanes merged like the slave
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_q <= 1'b0;
         locked <= 1'b0;
         cfg_m <= WWD_CFG_RESET;
      end else begin
         req_q <= req & ~acc;
         if (avs_write && acc && avs_address == WWD_CFG_OFS && !locked) begin
            locked <= 1'b1;
            for (int i = 0; i < 4; i++) begin
               if (avs_byteenable[i]) begin
                  cfg_m[8*i +: 8] <= avs_writedata[8*i +: 8];
               end
            end
         end
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   wait_first_a: assert property (req && !req_q |-> avs_waitrequest)
      else $error("no wait cycle on a new request");
   one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait cycle");
   idle_wait_a: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest while idle");
   cmd_zero_a: assert property (acc && avs_read &&
      (avs_address == WWD_CMD_OFS || avs_address > WWD_CNT_OFS)
      |-> avs_readdata == 32'h0)
      else $error("command or unmapped read not zero");
   cfg_once_a: assert property (acc && avs_read &&
      avs_address == WWD_CFG_OFS |-> avs_readdata == cfg_m)
      else $error("configuration readback differs");
   sts_bits_a: assert property (sts_rd |-> avs_readdata[31:2] == 30'h0)
      else $error("status upper bits set");
   irq_gate_a: assert property (fault_irq |-> cfg_m[12] || $past(cfg_m[12]))
      else $error("interrupt while disabled");
   fault_gate_a: assert property ($rose(fault_request) |-> $past(cfg_m[13]))
      else $error("fault request while reset disabled");
   scope_a: assert property (processor_only_reset == $past(cfg_m[14]))
      else $error("reset scope not the configured one");
   read_clear_a: assert property (sts_rd |=> ##1
      !fault_irq && !fault_request)
      else $error("status read left a fault raised");

   // main scenarios seen
   cover property (sts_rd && avs_readdata[0]);
   cover property (sts_rd && avs_readdata[1]);
   cover property ($rose(fault_request));
   cover property ($rose(fault_irq));
endmodule : wwd_watchdog_props

bind wwd_watchdog wwd_watchdog_props #(.DIV(DIV)) i_props (
   .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .slow_clk(slow_clk), .proc_debug(proc_debug), .sys_idle(sys_idle),
   .fault_irq(fault_irq), .fault_request(fault_request),
   .processor_only_reset(processor_only_reset));

/* verilog/wwd_pkg.sv */
// constants, register layout and types of the windowed watchdog
package wwd_pkg;

   // register byte offsets
   localparam logic [4:0] WWD_CMD_OFS = 5'h00;
   localparam logic [4:0] WWD_CFG_OFS = 5'h04;
   localparam logic [4:0] WWD_STS_OFS = 5'h08;
   localparam logic [4:0] WWD_MASK_OFS = 5'h0C;
   localparam logic [4:0] WWD_CNT_OFS = 5'h10;

   // command register fields
   localparam logic [7:0] WWD_KEY = 8'hA5;
   localparam int WWD_KEY_LSB = 24;
   localparam int WWD_RESTART_BIT = 0;

   // reset values
   localparam logic [31:0] WWD_CFG_RESET = 32'h3FFF2FFF;
   localparam logic [1:0] WWD_STS_RESET = 2'h0;
   localparam logic [1:0] WWD_MASK_RESET = 2'h3;

   // slow clock prescaler
   localparam int WWD_PRESCALE = 128;

   // configuration register layout, bit 31 down to bit 0
   typedef struct packed {
      logic [1:0] reserved;
      logic idle_freeze;
      logic debug_freeze;
      logic [11:0] window_limit;
      logic timer_disable;
      logic processor_only_reset;
      logic fault_reset_enable;
      logic fault_irq_enable;
      logic [11:0] reload_value;
   } wwd_cfg_type;

   // fault flag layout, also used by the mask register
   typedef struct packed {
      logic window_error_flag;
      logic underflow_flag;
   } wwd_flags_type;

   // avalon handshake state
   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } wwd_bus_state_type;

endpackage : wwd_pkg

/* verilog/wwd_tick_gen.sv */
// slow clock synchroniser and divide-by-prescale tick generator
`timescale 1ns/10ps
module wwd_tick_gen
   import wwd_pkg::*;
#(
   parameter int DIV = WWD_PRESCALE
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic slow_clk,
   input wire logic run,
   input wire logic restart,
   output logic tick
);

   localparam int DW = $clog2(DIV);
   localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

   logic sync1;
   logic sync2;
   logic sync3;
   logic slow_lvl;
   logic slow_rise;
   logic [DW-1:0] div_cnt;

   // three-stage synchroniser; only sync2 reads sync1
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= slow_clk;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // a level change counts once the last two stages agree
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         slow_lvl <= 1'b0;
      end else if (sync2 == sync3) begin
         slow_lvl <= sync3;
      end
   end

   assign slow_rise = (sync2 == sync3) && sync3 && !slow_lvl;

   // divider halts with the counter so a freeze does not lose phase
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= '0;
         tick <= 1'b0;
      end else if (restart) begin
         div_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (slow_rise && run) begin
            if (div_cnt == DIV_LAST) begin
               div_cnt <= '0;
               tick <= 1'b1;
            end else begin
               div_cnt <= div_cnt + DW'(1);
            end
         end
      end
   end

endmodule : wwd_tick_gen

/* verilog/wwd_watchdog.sv */
// windowed watchdog core with its avalon register slave
`timescale 1ns/10ps
module wwd_watchdog
   import wwd_pkg::*;
#(
   parameter int DIV = WWD_PRESCALE
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic slow_clk,
   input wire logic proc_debug,
   input wire logic sys_idle,
   output logic fault_irq,
   output logic fault_request,
   output logic processor_only_reset
);

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_word[b*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   // address decode used by both the read and the write path
   function automatic logic hit(
      input logic [4:0] addr,
      input logic [4:0] ofs
   );
      return addr == ofs;
   endfunction : hit

   wwd_bus_state_type bus_state;
   wwd_bus_state_type next_bus_state;
   wwd_cfg_type cfg;
   wwd_cfg_type next_cfg;
   wwd_flags_type status;
   wwd_flags_type next_status;
   wwd_flags_type mask;
   wwd_flags_type fault_set;
   logic cfg_locked;
   logic [11:0] count;
   logic [1:0] hold_s1;
   logic [1:0] hold_s2;
   logic [1:0] hold_s3;
   logic [1:0] hold_lvl;
   logic in_debug;
   logic in_idle;
   logic wr_take;
   logic rd_take;
   logic [31:0] cmd_word;
   logic key_ok;
   logic restart_try;
   logic window_err;
   logic restart_ok;
   logic cfg_take;
   logic running;
   logic tick;
   logic underflow;
   logic status_read;
   logic fault_any;

   // debug and idle come from the processor domain: three flops each
   generate
      for (genvar i = 0; i < 2; i++) begin : g_hold_sync
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               hold_s1[i] <= 1'b0;
               hold_s2[i] <= 1'b0;
               hold_s3[i] <= 1'b0;
               hold_lvl[i] <= 1'b0;
            end else begin
               hold_s1[i] <= (i == 0) ? proc_debug : sys_idle;
               hold_s2[i] <= hold_s1[i];
               hold_s3[i] <= hold_s2[i];
               if (hold_s2[i] == hold_s3[i]) begin
                  hold_lvl[i] <= hold_s3[i];
               end
            end
         end
      end
   endgenerate

   assign in_debug = hold_lvl[0];
   assign in_idle = hold_lvl[1];

   // avalon handshake: every access waits exactly one cycle
   always_comb begin
      next_bus_state = BUS_IDLE;
      case (bus_state)
         BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_bus_state = BUS_ACK;
            end
         end
         BUS_ACK: begin
            next_bus_state = BUS_IDLE;
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bus_state <= BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && (bus_state != BUS_ACK);

   // accesses take effect only at the edge where waitrequest is low
   assign wr_take = avs_write && (bus_state == BUS_ACK);
   assign rd_take = avs_read && (bus_state == BUS_ACK);

   // restart command decode; an unwritten key lane reads as zero
   assign cmd_word = be_merge(32'h00000000, avs_writedata, avs_byteenable);
   assign key_ok = cmd_word[WWD_KEY_LSB +: 8] == WWD_KEY;
   assign restart_try = wr_take && hit(avs_address, WWD_CMD_OFS)
      && key_ok && cmd_word[WWD_RESTART_BIT];

   // the window check ignores the disable bit on purpose
   assign window_err = restart_try && (count > cfg.window_limit);
   assign restart_ok = restart_try && !window_err;

   // configuration write is refused once locked
   assign cfg_take = wr_take && hit(avs_address, WWD_CFG_OFS)
      && !cfg_locked;
   assign next_cfg = wwd_cfg_type'(be_merge(cfg, avs_writedata,
      avs_byteenable));

   // counter runs unless disabled or frozen by debug or idle
   assign running = !cfg.timer_disable
      && !(cfg.debug_freeze && in_debug)
      && !(cfg.idle_freeze && in_idle);

   wwd_tick_gen #(
      .DIV(DIV)
   ) u_tick (
      .mclk(mclk),
      .rst_b(rst_b),
      .slow_clk(slow_clk),
      .run(running),
      .restart(restart_ok || cfg_take),
      .tick(tick)
   );

   assign underflow = tick && running && (count == 12'h000);

   // configuration register, write once per processor reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= wwd_cfg_type'(WWD_CFG_RESET);
         cfg_locked <= 1'b0;
      end else if (cfg_take) begin
         cfg <= next_cfg;
         cfg_locked <= 1'b1;
      end
   end

   // down counter; a config write loads the new value at once
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count <= WWD_CFG_RESET[11:0];
      end else if (cfg_take) begin
         count <= next_cfg.reload_value;
      end else if (restart_ok || underflow) begin
         count <= cfg.reload_value;
      end else if (tick && running) begin
         count <= count - 12'h001;
      end
   end

   // fault events; set wins over the read clear
   assign fault_set.window_error_flag = window_err;
   assign fault_set.underflow_flag = underflow;
   assign fault_any = window_err || underflow;
   assign status_read = rd_take && hit(avs_address, WWD_STS_OFS);

   always_comb begin
      next_status = status;
      if (status_read) begin
         next_status = wwd_flags_type'(WWD_STS_RESET);
      end
      next_status = next_status | fault_set;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         status <= wwd_flags_type'(WWD_STS_RESET);
      end else begin
         status <= next_status;
      end
   end

   // interrupt mask, same layout as the status flags
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mask <= wwd_flags_type'(WWD_MASK_RESET);
      end else if (wr_take && hit(avs_address, WWD_MASK_OFS)) begin
         mask <= wwd_flags_type'(avs_writedata[1:0]);
      end
   end

   // interrupt level follows the flags so a read drops it
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fault_irq <= 1'b0;
      end else begin
         fault_irq <= cfg.fault_irq_enable
            && (|(next_status & mask));
      end
   end

   // fault line to the reset controller; held until a status read
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fault_request <= 1'b0;
      end else if (fault_any && cfg.fault_reset_enable) begin
         fault_request <= 1'b1;
      end else if (status_read) begin
         fault_request <= 1'b0;
      end
   end

   // reset scope travels with the request; the controller samples both
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         processor_only_reset <= WWD_CFG_RESET[14];
      end else begin
         processor_only_reset <= cfg.processor_only_reset;
      end
   end

   // read data prepared in the waiting cycle, stands when waitrequest falls
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && bus_state == BUS_IDLE) begin
         if (hit(avs_address, WWD_CFG_OFS)) begin
            avs_readdata <= cfg;
         end else if (hit(avs_address, WWD_STS_OFS)) begin
            avs_readdata <= {30'h00000000, status};
         end else if (hit(avs_address, WWD_MASK_OFS)) begin
            avs_readdata <= {30'h00000000, mask};
         end else if (hit(avs_address, WWD_CNT_OFS)) begin
            avs_readdata <= {20'h00000, count};
         end else begin
            avs_readdata <= 32'h00000000; // command is write-only
         end
      end
   end

endmodule : wwd_watchdog
